// *** verilog/serial_out1_mixer.sv ***
// Operation
// - Four left-stream paths each own 5-bit gain
// - Gain code steps 1.5 dB, 0x1c is unity
// - Every gain field resets to 0x1c
// - Six right-stream paths have separate gains
// - Right source mask is 7 bits, fixed layout
// - Cleared mask bit drops that source
// - Set mask bit adds source times gain
// - Right source mask resets to 0x4
module serial_out1_mixer (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   // Register bus, write address and data
   input wire logic [mixer_pkg::AXI_ADDR_W-1:0] AXI_AWADDR_IN,
   input wire logic AXI_AWVALID_IN,
   output logic AXI_AWREADY_OUT,
   input wire logic [31:0] AXI_WDATA_IN,
   input wire logic [3:0] AXI_WSTRB_IN,
   input wire logic AXI_WVALID_IN,
   output logic AXI_WREADY_OUT,
   // Register bus, write response
   output logic [1:0] AXI_BRESP_OUT,
   output logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   // Register bus, read
   input wire logic [mixer_pkg::AXI_ADDR_W-1:0] AXI_ARADDR_IN,
   input wire logic AXI_ARVALID_IN,
   output logic AXI_ARREADY_OUT,
   output logic [31:0] AXI_RDATA_OUT,
   output logic [1:0] AXI_RRESP_OUT,
   output logic AXI_RVALID_OUT,
   input wire logic AXI_RREADY_IN,
   // Source samples
   input wire logic SAMPLE_STROBE_IN,
   input wire mixer_pkg::source_set_t SOURCES_IN,
   // Output stream
   output logic TX_VALID_OUT,
   input wire logic TX_READY_IN,
   output mixer_pkg::stereo_t TX_DATA_OUT
);
   localparam int SC = mixer_pkg::SRC_COUNT;
   localparam int GW = mixer_pkg::GAIN_W;
   localparam int MW = mixer_pkg::MASK_W;
   // Bus state
   logic aw_held, w_held, awready, wready, bvalid, arready, rvalid;
   logic next_aw_held, next_w_held, next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [mixer_pkg::AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data, rdata, next_rdata;
   logic w_strb0, next_w_strb0;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic do_write, wr_hit, rd_hit;
   logic [7:0] wr_idx, rd_idx;
   logic [31:0] rd_word;
   // Register state
   logic [GW-1:0] gain_l [SC];
   logic [GW-1:0] gain_r [SC];
   logic [GW-1:0] next_gain_l [SC];
   logic [GW-1:0] next_gain_r [SC];
   logic [MW-1:0] mask_l, mask_r, next_mask_l, next_mask_r;
   logic [mixer_pkg::ST_STICKY_W-1:0] sticky, next_sticky, sticky_set;
   logic [SC-1:0] wr_gain_l, wr_gain_r;
   // Mixer state
   mixer_pkg::mix_state_t state, next_state;
   logic [2:0] src_idx, next_src_idx;
   mixer_pkg::source_set_t held_src, next_held_src;
   logic signed [mixer_pkg::ACC_W-1:0] acc_l, acc_r, next_acc_l, next_acc_r;
   logic signed [mixer_pkg::PROD_W-1:0] prod_l, prod_r, term_l, term_r;
   mixer_pkg::sample_t cur_sample;
   logic [mixer_pkg::SAMPLE_W-1:0] sat_l, sat_r;
   logic clip_l, clip_r;
   logic buf_ready, buf_valid;
   mixer_pkg::stereo_t buf_data;
   // Per-path gain write decode
   generate
      for (genvar s = 0; s < SC; s++) begin : g_path
         assign wr_gain_l[s] = do_write && w_strb0 && mixer_pkg::LEFT_GAIN_IDX[s] != mixer_pkg::NO_REG_IDX
            && wr_idx == mixer_pkg::LEFT_GAIN_IDX[s];
         assign wr_gain_r[s] = do_write && w_strb0 && mixer_pkg::RIGHT_GAIN_IDX[s] != mixer_pkg::NO_REG_IDX
            && wr_idx == mixer_pkg::RIGHT_GAIN_IDX[s];
      end
   endgenerate
   function automatic logic idx_mapped(input logic [mixer_pkg::AXI_ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      idx_mapped = a[11:10] == 2'h0 && ((i >= mixer_pkg::LEFT_F2R_GAIN_IDX && i <= mixer_pkg::RIGHT_RXL_GAIN_IDX)
         || i == mixer_pkg::LEFT_MASK_IDX || i == mixer_pkg::STATUS_IDX);
   endfunction
   // Register bus slave
   always_comb begin
      wr_idx = aw_addr[9:2];
      wr_hit = idx_mapped(aw_addr);
      rd_idx = AXI_ARADDR_IN[9:2];
      rd_hit = idx_mapped(AXI_ARADDR_IN);
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb0 = w_strb0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (AXI_AWVALID_IN && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && wready) begin
         next_w_held = 1'b1;
         next_w_data = AXI_WDATA_IN;
         next_w_strb0 = AXI_WSTRB_IN[0];
      end
      if (bvalid && AXI_BREADY_IN) begin
         next_bvalid = 1'b0;
      end
      do_write = aw_held && w_held && !bvalid;
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_hit ? mixer_pkg::RESP_OKAY : mixer_pkg::RESP_SLVERR;
      end
      if (rvalid && AXI_RREADY_IN) begin
         next_rvalid = 1'b0;
      end
      if (AXI_ARVALID_IN && arready) begin
         next_rvalid = 1'b1;
         next_rdata = rd_word;
         next_rresp = rd_hit ? mixer_pkg::RESP_OKAY : mixer_pkg::RESP_SLVERR;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb0 <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= mixer_pkg::RESP_OKAY;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= mixer_pkg::RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb0 <= next_w_strb0;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end
   // Read data select
   always_comb begin
      rd_word = '0;
      for (int s = 0; s < SC; s++) begin
         if (mixer_pkg::LEFT_GAIN_IDX[s] != mixer_pkg::NO_REG_IDX && rd_idx == mixer_pkg::LEFT_GAIN_IDX[s]) begin
            rd_word[GW-1:0] = gain_l[s];
         end
         if (mixer_pkg::RIGHT_GAIN_IDX[s] != mixer_pkg::NO_REG_IDX && rd_idx == mixer_pkg::RIGHT_GAIN_IDX[s]) begin
            rd_word[GW-1:0] = gain_r[s];
         end
      end
      if (rd_idx == mixer_pkg::RIGHT_MASK_IDX) begin
         rd_word[MW-1:0] = mask_r;
      end
      if (rd_idx == mixer_pkg::LEFT_MASK_IDX) begin
         rd_word[MW-1:0] = mask_l;
      end
      if (rd_idx == mixer_pkg::STATUS_IDX) begin
         rd_word[mixer_pkg::ST_STICKY_W-1:0] = sticky;
         rd_word[mixer_pkg::ST_BUSY] = state != mixer_pkg::MIX_IDLE;
         rd_word[mixer_pkg::ST_BUF_FULL] = !buf_ready;
      end
      if (!rd_hit) begin
         rd_word = '0;
      end
   end
   // Control registers
   always_comb begin
      next_gain_l = gain_l;
      next_gain_r = gain_r;
      next_mask_l = mask_l;
      next_mask_r = mask_r;
      for (int s = 0; s < SC; s++) begin
         if (wr_gain_l[s]) begin
            next_gain_l[s] = w_data[GW-1:0];
         end
         if (wr_gain_r[s]) begin
            next_gain_r[s] = w_data[GW-1:0];
         end
      end
      if (do_write && w_strb0 && wr_idx == mixer_pkg::RIGHT_MASK_IDX) begin
         next_mask_r = w_data[MW-1:0];
      end
      if (do_write && w_strb0 && wr_idx == mixer_pkg::LEFT_MASK_IDX) begin
         next_mask_l = w_data[MW-1:0];
      end
      next_sticky = sticky;
      if (do_write && w_strb0 && wr_idx == mixer_pkg::STATUS_IDX) begin
         next_sticky = sticky & ~w_data[mixer_pkg::ST_STICKY_W-1:0];
      end
      next_sticky = next_sticky | sticky_set;
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         for (int s = 0; s < SC; s++) begin
            gain_l[s] <= mixer_pkg::GAIN_RESET;
            gain_r[s] <= mixer_pkg::GAIN_RESET;
         end
         mask_r <= mixer_pkg::RIGHT_MASK_RESET;
         mask_l <= mixer_pkg::LEFT_MASK_RESET;
         sticky <= '0;
      end else begin
         gain_l <= next_gain_l;
         gain_r <= next_gain_r;
         mask_r <= next_mask_r;
         mask_l <= next_mask_l;
         sticky <= next_sticky;
      end
   end

   function automatic logic [mixer_pkg::SAMPLE_W:0] saturate(input logic signed [mixer_pkg::ACC_W-1:0] a);
      logic signed [mixer_pkg::ACC_W-1:0] hi, lo;
      hi = mixer_pkg::ACC_W'({1'b0, {(mixer_pkg::SAMPLE_W-1){1'b1}}});
      lo = -hi - mixer_pkg::ACC_W'(1);
      if (a > hi) begin
         saturate = {1'b1, hi[mixer_pkg::SAMPLE_W-1:0]};
      end else if (a < lo) begin
         saturate = {1'b1, lo[mixer_pkg::SAMPLE_W-1:0]};
      end else begin
         saturate = {1'b0, a[mixer_pkg::SAMPLE_W-1:0]};
      end
   endfunction
   // Sample mixer
   always_comb begin
      cur_sample = mixer_pkg::sample_t'(held_src.src[src_idx]);
      prod_l = cur_sample * $signed({1'b0, mixer_pkg::GAIN_TABLE[gain_l[src_idx]]});
      prod_r = cur_sample * $signed({1'b0, mixer_pkg::GAIN_TABLE[gain_r[src_idx]]});
      term_l = mask_l[src_idx] ? prod_l >>> mixer_pkg::GAIN_FRAC : $signed(mixer_pkg::PROD_W'(0));
      term_r = mask_r[src_idx] ? prod_r >>> mixer_pkg::GAIN_FRAC : $signed(mixer_pkg::PROD_W'(0));
      {clip_l, sat_l} = saturate(acc_l);
      {clip_r, sat_r} = saturate(acc_r);
      buf_valid = state == mixer_pkg::MIX_PUSH;
      buf_data = '{left: sat_l, right: sat_r};
      next_state = state;
      next_src_idx = src_idx;
      next_held_src = held_src;
      next_acc_l = acc_l;
      next_acc_r = acc_r;
      sticky_set = '0;
      case (state)
         mixer_pkg::MIX_IDLE: begin
            if (SAMPLE_STROBE_IN) begin
               next_held_src = SOURCES_IN;
               next_acc_l = '0;
               next_acc_r = '0;
               next_src_idx = '0;
               next_state = mixer_pkg::MIX_ACCUM;
            end
         end
         mixer_pkg::MIX_ACCUM: begin
            next_acc_l = acc_l + term_l[mixer_pkg::ACC_W-1:0];
            next_acc_r = acc_r + term_r[mixer_pkg::ACC_W-1:0];
            next_src_idx = src_idx + 3'h1;
            if (src_idx == 3'(SC - 1)) begin
               next_state = mixer_pkg::MIX_PUSH;
            end
         end
         mixer_pkg::MIX_PUSH: begin
            if (buf_ready) begin
               sticky_set[mixer_pkg::ST_LEFT_CLIP] = clip_l;
               sticky_set[mixer_pkg::ST_RIGHT_CLIP] = clip_r;
               next_state = mixer_pkg::MIX_IDLE;
            end
         end
         default: begin
            next_state = mixer_pkg::MIX_IDLE;
         end
      endcase
      if (SAMPLE_STROBE_IN && state != mixer_pkg::MIX_IDLE) begin
         sticky_set[mixer_pkg::ST_OVERRUN] = 1'b1;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         state <= mixer_pkg::MIX_IDLE;
         src_idx <= '0;
         held_src <= '0;
         acc_l <= '0;
         acc_r <= '0;
      end else begin
         state <= next_state;
         src_idx <= next_src_idx;
         held_src <= next_held_src;
         acc_l <= next_acc_l;
         acc_r <= next_acc_r;
      end
   end
   sample_skid_buffer u_out_buffer (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .in_valid_in(buf_valid),
      .in_ready_out(buf_ready),
      .in_data_in(buf_data),
      .out_valid_out(TX_VALID_OUT),
      .out_ready_in(TX_READY_IN),
      .out_data_out(TX_DATA_OUT)
   );
   assign AXI_AWREADY_OUT = awready;
   assign AXI_WREADY_OUT = wready;
   assign AXI_BVALID_OUT = bvalid;
   assign AXI_BRESP_OUT = bresp;
   assign AXI_ARREADY_OUT = arready;
   assign AXI_RVALID_OUT = rvalid;
   assign AXI_RDATA_OUT = rdata;
   assign AXI_RRESP_OUT = rresp;

endmodule

// *** verilog/mixer_pkg.sv ***
package mixer_pkg;

   // Data path sizes
   localparam int SRC_COUNT = 7;
   localparam int SAMPLE_W = 24;
   localparam int GAIN_W = 5;
   localparam int MASK_W = 7;
   localparam int LIN_W = 16;
   localparam int GAIN_FRAC = 14;
   localparam int ACC_W = 30;
   localparam int PROD_W = 41;
   localparam int AXI_ADDR_W = 12;

   // Source bit positions in a source mask
   localparam int SRC_F1L = 0;
   localparam int SRC_F1R = 1;
   localparam int SRC_F2L = 2;
   localparam int SRC_F2R = 3;
   localparam int SRC_TONE = 4;
   localparam int SRC_RXL = 5;
   localparam int SRC_RXR = 6;

   // Register indices; byte address is four times the index
   localparam logic [7:0] LEFT_F2R_GAIN_IDX = 8'h60;
   localparam logic [7:0] LEFT_TONE_GAIN_IDX = 8'h61;
   localparam logic [7:0] LEFT_RXL_GAIN_IDX = 8'h62;
   localparam logic [7:0] LEFT_RXR_GAIN_IDX = 8'h63;
   localparam logic [7:0] RIGHT_MASK_IDX = 8'h64;
   localparam logic [7:0] RIGHT_F1L_GAIN_IDX = 8'h65;
   localparam logic [7:0] RIGHT_F1R_GAIN_IDX = 8'h66;
   localparam logic [7:0] RIGHT_F2L_GAIN_IDX = 8'h67;
   localparam logic [7:0] RIGHT_F2R_GAIN_IDX = 8'h68;
   localparam logic [7:0] RIGHT_TONE_GAIN_IDX = 8'h69;
   localparam logic [7:0] RIGHT_RXL_GAIN_IDX = 8'h6a;
   localparam logic [7:0] LEFT_MASK_IDX = 8'h70;
   localparam logic [7:0] STATUS_IDX = 8'h71;
   localparam logic [7:0] NO_REG_IDX = 8'hff;

   // Path gain register per source, NO_REG_IDX where the path is fixed
   localparam logic [7:0] LEFT_GAIN_IDX [SRC_COUNT] = '{NO_REG_IDX, NO_REG_IDX, NO_REG_IDX,
      LEFT_F2R_GAIN_IDX, LEFT_TONE_GAIN_IDX, LEFT_RXL_GAIN_IDX, LEFT_RXR_GAIN_IDX};
   localparam logic [7:0] RIGHT_GAIN_IDX [SRC_COUNT] = '{RIGHT_F1L_GAIN_IDX, RIGHT_F1R_GAIN_IDX,
      RIGHT_F2L_GAIN_IDX, RIGHT_F2R_GAIN_IDX, RIGHT_TONE_GAIN_IDX, RIGHT_RXL_GAIN_IDX, NO_REG_IDX};

   // Reset values
   localparam logic [GAIN_W-1:0] GAIN_RESET = 5'h1c;
   localparam logic [MASK_W-1:0] RIGHT_MASK_RESET = 7'h04;
   localparam logic [MASK_W-1:0] LEFT_MASK_RESET = 7'h78;

   // Status bits
   localparam int ST_LEFT_CLIP = 0;
   localparam int ST_RIGHT_CLIP = 1;
   localparam int ST_OVERRUN = 2;
   localparam int ST_BUSY = 3;
   localparam int ST_BUF_FULL = 4;
   localparam int ST_STICKY_W = 3;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Linear gain, unity = 2^14, steps of 1.5 dB from -42 dB to +4.5 dB
   localparam logic [LIN_W-1:0] GAIN_TABLE [32] = '{
      16'h0082, 16'h009b, 16'h00b8, 16'h00da, 16'h0104, 16'h0135, 16'h016f, 16'h01b4,
      16'h0206, 16'h0268, 16'h02dc, 16'h0366, 16'h040a, 16'h04cd, 16'h05b4, 16'h06c7,
      16'h080f, 16'h0993, 16'h0b62, 16'h0d87, 16'h1013, 16'h131b, 16'h16b5, 16'h1aed,
      16'h2013, 16'h261f, 16'h2d4f, 16'h35da, 16'h4000, 16'h4c11, 16'h5a67, 16'h6b72};

   typedef logic signed [SAMPLE_W-1:0] sample_t;

   typedef struct packed {
      logic [SRC_COUNT-1:0][SAMPLE_W-1:0] src;
   } source_set_t;

   typedef struct packed {
      logic [SAMPLE_W-1:0] left;
      logic [SAMPLE_W-1:0] right;
   } stereo_t;

   typedef enum logic [1:0] {MIX_IDLE, MIX_ACCUM, MIX_PUSH} mix_state_t;

endpackage

// *** verilog/sample_skid_buffer.sv ***
module sample_skid_buffer (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Filling side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire mixer_pkg::stereo_t in_data_in,
   // Draining side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output mixer_pkg::stereo_t out_data_out
);

   logic head_v, tail_v, next_head_v, next_tail_v;
   mixer_pkg::stereo_t head, tail, next_head, next_tail;
   logic push, pop;

   always_comb begin
      push = in_valid_in && !tail_v;
      pop = head_v && out_ready_in;
      next_head_v = head_v;
      next_tail_v = tail_v;
      next_head = head;
      next_tail = tail;
      if (pop || !head_v) begin
         if (tail_v) begin
            next_head = tail;
            next_head_v = 1'b1;
            next_tail_v = 1'b0;
            if (push) begin
               next_tail = in_data_in;
               next_tail_v = 1'b1;
            end
         end else if (push) begin
            next_head = in_data_in;
            next_head_v = 1'b1;
         end else begin
            next_head_v = 1'b0;
         end
      end else if (push) begin
         next_tail = in_data_in;
         next_tail_v = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         head_v <= 1'b0;
         tail_v <= 1'b0;
         head <= '0;
         tail <= '0;
      end else begin
         head_v <= next_head_v;
         tail_v <= next_tail_v;
         head <= next_head;
         tail <= next_tail;
      end
   end

   assign in_ready_out = !tail_v;
   assign out_valid_out = head_v;
   assign out_data_out = head;

endmodule

// *** tb/mixer_asserts.sv ***
module mixer_asserts (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   // Register bus
   input wire logic AXI_AWVALID_IN,
   input wire logic AXI_AWREADY_OUT,
   input wire logic AXI_WVALID_IN,
   input wire logic AXI_WREADY_OUT,
   input wire logic [1:0] AXI_BRESP_OUT,
   input wire logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   input wire logic [mixer_pkg::AXI_ADDR_W-1:0] AXI_ARADDR_IN,
   input wire logic AXI_ARVALID_IN,
   input wire logic AXI_ARREADY_OUT,
   input wire logic [31:0] AXI_RDATA_OUT,
   input wire logic [1:0] AXI_RRESP_OUT,
   input wire logic AXI_RVALID_OUT,
   input wire logic AXI_RREADY_IN,
   // Output stream
   input wire logic TX_VALID_OUT,
   input wire logic TX_READY_IN,
   input wire mixer_pkg::stereo_t TX_DATA_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ar_map;
   assign ar_map = AXI_ARADDR_IN[11:10] == 2'h0 && (AXI_ARADDR_IN[9:2] inside {[8'h60:8'h6a], 8'h70, 8'h71});
   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);
   a_b_holds: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
      else $error("write response dropped early");
   a_r_holds: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT))
      else $error("read data dropped early");
   a_write_answer: assert property (AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT
      |-> ##2 AXI_BVALID_OUT) else $error("write response late");
   a_read_answer: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT)
      else $error("read data late");
   a_read_resp: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT
      |=> AXI_RRESP_OUT == (ar_map ? mixer_pkg::RESP_OKAY : mixer_pkg::RESP_SLVERR))
      else $error("wrong read response");
   a_reserved_zero: assert property (AXI_RVALID_OUT |-> AXI_RDATA_OUT[31:7] == 25'h0)
      else $error("reserved read bits set");
   a_tx_holds: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
      else $error("stream word lost");
   a_reset_idle: assert property (disable iff (1'b0) !RST_B_IN |=> !TX_VALID_OUT && !AXI_BVALID_OUT
      && !AXI_RVALID_OUT) else $error("busy after reset");
endmodule

bind serial_out1_mixer mixer_asserts u_mixer_asserts (.CLK_IN, .RST_B_IN, .AXI_AWVALID_IN, .AXI_AWREADY_OUT,
   .AXI_WVALID_IN, .AXI_WREADY_OUT, .AXI_BRESP_OUT, .AXI_BVALID_OUT, .AXI_BREADY_IN, .AXI_ARADDR_IN,
   .AXI_ARVALID_IN, .AXI_ARREADY_OUT, .AXI_RDATA_OUT, .AXI_RRESP_OUT, .AXI_RVALID_OUT, .AXI_RREADY_IN,
   .TX_VALID_OUT, .TX_READY_IN, .TX_DATA_OUT);

// *** tb/far_end_model.sv ***
module far_end_model (
   // Clock
   input wire logic clk_in,
   // Control from bench
   input wire logic load_in,
   input wire mixer_pkg::source_set_t load_data_in,
   input wire logic stall_in,
   // Toward mixer
   output logic strobe_out,
   output mixer_pkg::source_set_t sources_out,
   output logic tx_ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      strobe_out = 1'b0;
      sources_out = '0;
      tx_ready_out = 1'b1;
   end
   always @(posedge clk_in) begin
      strobe_out <= load_in;
      // Lines change every cycle between strobes
      sources_out <= load_in ? load_data_in : ~sources_out;
      tx_ready_out <= !stall_in;
   end
endmodule

// *** tb/tb_serial_out1_digital_mixer.sv ***
module tb_serial_out1_digital_mixer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, load = 1'b0, stall = 1'b0;
   logic lazy = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic [3:0] strb_sel = 4'h1;
   logic awready, wready, bvalid, arready, rvalid, strobe, tx_valid, tx_ready;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   mixer_pkg::source_set_t sources, load_data = '0;
   mixer_pkg::stereo_t tx_data;
   mixer_pkg::stereo_t exp_q [$];
   int failures = 0, compares = 0;
   logic [7:0] sh [0:255];
   logic [7:0] cfg [12] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h70};

   always #12.5 clk = ~clk;

   serial_out1_mixer u_serial_out1_mixer (
      .CLK_IN(clk), .RST_B_IN(rst_b),
      .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
      .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
      .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
      .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
      .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready),
      .SAMPLE_STROBE_IN(strobe), .SOURCES_IN(sources),
      .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready), .TX_DATA_OUT(tx_data));

   far_end_model u_far_end_model (.clk_in(clk), .load_in(load), .load_data_in(load_data), .stall_in(stall),
      .strobe_out(strobe), .sources_out(sources), .tx_ready_out(tx_ready));

   task automatic complete_run;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [47:0] e, input logic [47:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] resp);
      @(posedge clk);
      awaddr <= {2'h0, idx, 2'h0};
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= strb_sel;
      wvalid <= 1'b1;
      bready <= !lazy;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
      @(posedge clk);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= !lazy;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic cfg_wr(input logic [7:0] idx, input logic [31:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      sh[idx] = d[7:0] & (idx == 8'h64 || idx == 8'h70 ? 8'h7f : 8'h1f);
      chk("bresp", mixer_pkg::RESP_OKAY, r);
   endtask

   task automatic rb(input logic [7:0] idx);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      chk($sformatf("reg %h", idx), sh[idx], d);
      chk("rresp", mixer_pkg::RESP_OKAY, r);
   endtask

   function automatic logic [23:0] mix(mixer_pkg::source_set_t s, logic [7:0] mi, logic [7:0] gi [7]);
      longint acc;
      logic [4:0] g;
      acc = 0;
      for (int i = 0; i < 7; i++) begin
         g = gi[i] == mixer_pkg::NO_REG_IDX ? 5'h1c : sh[gi[i]][4:0];
         if (sh[mi][i]) acc += (longint'($signed(s.src[i])) * longint'(mixer_pkg::GAIN_TABLE[g])) >>> 14;
      end
      if (acc > 8388607) acc = 8388607;
      if (acc < -8388608) acc = -8388608;
      return acc[23:0];
   endfunction

   function automatic mixer_pkg::source_set_t rnd();
      mixer_pkg::source_set_t s;
      for (int i = 0; i < 7; i++) s.src[i] = 24'($urandom);
      return s;
   endfunction

   task automatic fire(input mixer_pkg::source_set_t s, input logic push);
      @(posedge clk);
      load <= 1'b1;
      load_data <= s;
      if (push) exp_q.push_back({mix(s, 8'h70, mixer_pkg::LEFT_GAIN_IDX), mix(s, 8'h64, mixer_pkg::RIGHT_GAIN_IDX)});
      @(posedge clk);
      load <= 1'b0;
      repeat (10) @(posedge clk);
   endtask

   always @(posedge clk) begin
      if (rst_b && tx_valid && tx_ready) begin
         if (exp_q.size() == 0) chk("tx count", 48'h0, 48'h1);
         else chk("tx data", exp_q.pop_front(), tx_data);
      end
   end

   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      complete_run;
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      mixer_pkg::source_set_t s;
      void'($urandom(32'h9d06));
      for (int i = 0; i < 256; i++) sh[i] = 8'h1c;
      sh[8'h64] = 8'h04;
      sh[8'h70] = 8'h78;
      sh[8'h71] = 8'h00;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      // Reset values, unmapped place
      foreach (cfg[i]) rb(cfg[i]);
      rb(8'h71);
      rd(8'h50, d, r);
      chk("unmapped rdata", 48'h0, d);
      chk("unmapped rresp", mixer_pkg::RESP_SLVERR, r);
      wr(8'h50, 32'hff, r);
      chk("unmapped bresp", mixer_pkg::RESP_SLVERR, r);
      fire(rnd(), 1'b1);
      // Full scale corners, then random settings
      for (int k = 0; k < 40; k++) begin
         foreach (cfg[i]) cfg_wr(cfg[i], k < 2 ? 32'hffffffff : $urandom);
         if (k == 2) cfg_wr(8'h64, 32'h0);
         if (k == 2) cfg_wr(8'h70, 32'h80);
         foreach (cfg[i]) rb(cfg[i]);
         s = rnd();
         if (k == 0) s = {7{24'h7fffff}};
         if (k == 1) s = {7{24'h800000}};
         fire(s, 1'b1);
      end
      // Stalled receiver: buffer fills, fourth strobe dropped
      stall <= 1'b1;
      for (int k = 0; k < 4; k++) fire(rnd(), k < 3);
      rd(8'h71, d, r);
      chk("status", 48'h1c, d & 32'h1c);
      stall <= 1'b0;
      repeat (20) @(posedge clk);
      chk("tx pending", 48'h0, exp_q.size());
      wr(8'h71, 32'h7, r);
      rd(8'h71, d, r);
      chk("status clear", 48'h0, d);
      // Late ready on both answers, write without byte strobe
      lazy = 1'b1;
      strb_sel = 4'h0;
      wr(8'h64, 32'h55, r);
      chk("unstrobed bresp", mixer_pkg::RESP_OKAY, r);
      strb_sel = 4'h1;
      rb(8'h64);
      lazy = 1'b0;
      complete_run;
   end
endmodule
